// file: core/cca_core.sv
// Counter array with independent capture/compare modules.
// Assumes a synchronous timebase tick, an Avalon-MM master and module lines that
// arrive asynchronously from pins.
// Operation
// - Capture copies counter into compare word
// - Capture edge select: rising, falling, both
// - Capture sets flag, requests interrupt if enabled
// - Flag cleared only by software
// - Timer mode flags on 16-bit equality
// - Timer mode: comparator and match enables
// - Low write clears, high write sets comparator
// - High-speed output toggles line on match
// - Frequency mode toggles, adds high to low
// - Frequency is timebase over twice high
// - Frequency mode: comparator, toggle, pulse enables
// - PWM8 high on match, low on wrap
// - PWM8 reloads low byte on wrap
// - PWM8 mode: comparator, pulse, narrow width
// - PWM8 duty 256 minus high over 256
// - PWM16 high on match, low on overflow
// - PWM16 mode: comparator, pulse, wide select
// - Each module runs independently
// - Overflow means counter wraps to zero
`timescale 1ns/1ps

module cca_core (
   input  wire logic                           clk_in,             // System clock, 100 MHz
   input  wire logic                           rst_n_in,           // Synchronous reset, low
   input  wire logic                           ce_in,              // Clock enable, freezes all
   input  wire logic                           tick_in,            // Timebase tick, same clock
   input  wire logic [cca_pkg::CCA_ADDR_W-1:0] avs_address,        // Byte address
   input  wire logic                           avs_read,           // Read request
   input  wire logic                           avs_write,          // Write request
   input  wire logic [31:0]                    avs_writedata,      // Write data
   input  wire logic [3:0]                     avs_byteenable,     // Byte lanes
   output logic [31:0]                         avs_readdata,       // Read data
   output logic                                avs_waitrequest,    // Wait request
   input  wire logic [cca_pkg::CCA_MODULES-1:0] io_line_in,        // module_io_line inputs
   output cca_pkg::cca_pins_type               io_line_out,        // Level and enable
   output logic                                irq_out             // Interrupt request
);
   import cca_pkg::*;

   // ==========================================================
   // Decoding helpers

   // Mode decode from one module_mode_reg value
   function automatic cca_mode_type decode_mode(input logic [7:0] m);
      cca_mode_type r;
      r = CCA_IDLE;
      if ((m[CCA_B_CAP_R] | m[CCA_B_CAP_F]) & ~m[CCA_B_MATCH] & ~m[CCA_B_TOGGLE]
          & ~m[CCA_B_PULSE]) begin
         r = CCA_CAPTURE;
      end else if (m[CCA_B_CMP_EN] & ~m[CCA_B_CAP_R] & ~m[CCA_B_CAP_F]) begin
         if (m[CCA_B_PULSE] & m[CCA_B_TOGGLE]) begin
            r = CCA_FREQ;
         end else if (m[CCA_B_PULSE]) begin
            r = m[CCA_B_WIDE] ? CCA_PWM16 : CCA_PWM8;
         end else if (m[CCA_B_MATCH] & m[CCA_B_TOGGLE]) begin
            r = CCA_HSO;
         end else if (m[CCA_B_MATCH]) begin
            r = CCA_TIMER;
         end
      end
      return r;
   endfunction

   // True when the byte address hits the given register
   function automatic logic hit(input logic [CCA_ADDR_W-1:0] a, input logic [7:0] off);
      return a[CCA_ADDR_W-1:2] == off[CCA_ADDR_W-1:2];
   endfunction

   // Module window base address
   function automatic logic [7:0] mod_base(input int i);
      return 8'(CCA_OFF_MOD0 + 8'(i) * CCA_MOD_STRIDE);
   endfunction

   // ==========================================================
   // State
   cca_state_type state_reg;      // Registered state
   cca_state_type state_next;     // Next state

   logic                         wr_fire;      // Write takes effect this edge
   logic                         tick_ok;      // Counter advances this edge
   logic [CCA_CNT_W-1:0]         cnt_new;      // Counter after increment
   logic                         ovf16;        // Full counter wraps
   logic                         ovf8;         // Low byte wraps
   logic [CCA_MODULES-1:0]       cap_ev;       // Capture event per module
   logic [CCA_MODULES-1:0]       match_ev;     // Compare event per module
   logic [CCA_MODULES-1:0]       wr_low;       // Low byte write per module
   logic [CCA_MODULES-1:0]       wr_high;      // High byte write per module
   logic [CCA_MODULES-1:0]       wr_mode;      // Mode write per module
   logic [CCA_MODULES-1:0]       flag_clr;     // Flag clear mask
   cca_mode_type                 md [CCA_MODULES];  // Decoded modes

   // Outputs come straight from the registered state
   assign avs_readdata    = state_reg.rdata;
   assign avs_waitrequest = state_reg.wait_req;
   assign io_line_out     = state_reg.pins;
   assign irq_out         = state_reg.irq;

   // Write lands only on the edge where waitrequest is seen low
   assign wr_fire = avs_write & ~state_reg.wait_req;
   assign tick_ok = tick_in & state_reg.run;
   assign cnt_new = state_reg.count + 16'h0001;
   // overflow is the wrap to zero
   assign ovf16   = tick_ok & (cnt_new == CCA_RST_COUNT);
   assign ovf8    = tick_ok & (cnt_new[7:0] == CCA_LOW_WRAP);

   // ==========================================================
   // Per-module decode, one copy per module
   genvar gi;
   generate
      for (gi = 0; gi < CCA_MODULES; gi++) begin : g_mod
         logic rise;   // Rising edge on synchronised line
         logic fall;   // Falling edge on synchronised line
         // edges seen only after the second stage
         assign rise = state_reg.sync2[gi] & ~state_reg.prev[gi];
         assign fall = ~state_reg.sync2[gi] & state_reg.prev[gi];
         assign md[gi] = decode_mode(state_reg.mode[gi]);
         assign cap_ev[gi] = (md[gi] == CCA_CAPTURE)
                           & ((rise & state_reg.mode[gi][CCA_B_CAP_R])
                           |  (fall & state_reg.mode[gi][CCA_B_CAP_F]));
         // Frequency mode matches the low byte only; others the full word
         assign match_ev[gi] = tick_ok & ((md[gi] == CCA_FREQ)
                             ? (cnt_new[7:0] == state_reg.cmp[gi][7:0])
                             : (cnt_new == state_reg.cmp[gi]));
         assign wr_mode[gi] = wr_fire & avs_byteenable[0]
                            & hit(avs_address, mod_base(gi) + {4'h0, CCA_SUB_MODE});
         assign wr_low[gi]  = wr_fire & avs_byteenable[0]
                            & hit(avs_address, mod_base(gi) + {4'h0, CCA_SUB_LOW});
         assign wr_high[gi] = wr_fire & avs_byteenable[0]
                            & hit(avs_address, mod_base(gi) + {4'h0, CCA_SUB_HIGH});
      end
   endgenerate

   // Write one to clear on the flag register
   assign flag_clr = (wr_fire & avs_byteenable[0] & hit(avs_address, CCA_OFF_FLAGS))
                   ? avs_writedata[CCA_MODULES-1:0] : '0;

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic [CCA_MODULES-1:0] flag_set;   // Hardware flag sets this edge
      logic [31:0]            rd;         // Read mux result
      state_next = state_reg;
      flag_set   = '0;
      rd         = 32'h0000_0000;

      // Counter advances on each enabled tick
      if (tick_ok) begin
         state_next.count = cnt_new;
      end

      // Synchroniser chain; first stage feeds only the second
      state_next.sync1 = io_line_in;
      state_next.sync2 = state_reg.sync1;
      state_next.prev  = state_reg.sync2;

      // each module acts on its own registers only
      for (int i = 0; i < CCA_MODULES; i++) begin
         // Line is driven while the toggle or pulse bit is set, released otherwise
         state_next.pins.oe_n[i] = ~(state_reg.mode[i][CCA_B_TOGGLE]
                                   | state_reg.mode[i][CCA_B_PULSE]);
         unique case (md[i])
            CCA_CAPTURE: begin
               if (cap_ev[i]) begin
                  state_next.cmp[i] = state_reg.count;
                  flag_set[i] = 1'b1;
               end
            end
            CCA_TIMER: begin
               if (match_ev[i]) begin
                  flag_set[i] = 1'b1;
               end
            end
            CCA_HSO: begin
               if (match_ev[i]) begin
                  state_next.pins.level[i] = ~state_reg.pins.level[i];
                  flag_set[i] = 1'b1;
               end
            end
            CCA_FREQ: begin
               if (match_ev[i]) begin
                  // toggle and step the low byte
                  state_next.pins.level[i] = ~state_reg.pins.level[i];
                  // a zero step wraps to a full 256 count
                  state_next.cmp[i][7:0] = 8'(state_reg.cmp[i][7:0]
                                            + state_reg.cmp[i][15:8]);
                  flag_set[i] = state_reg.mode[i][CCA_B_MATCH];
               end
            end
            CCA_PWM8: begin
               if (ovf8) begin
                  // reload low from high on wrap
                  state_next.cmp[i][7:0] = state_reg.cmp[i][15:8];
                  // low on wrap unless high byte is zero
                  state_next.pins.level[i] = (state_reg.cmp[i][15:8] == CCA_LOW_WRAP);
               end else if (match_ev[i] || (tick_ok
                            && cnt_new[7:0] == state_reg.cmp[i][7:0])) begin
                  state_next.pins.level[i] = 1'b1;
               end
               flag_set[i] = state_reg.mode[i][CCA_B_MATCH] & tick_ok
                           & (cnt_new[7:0] == state_reg.cmp[i][7:0]);
            end
            CCA_PWM16: begin
               if (ovf16) begin
                  // low on overflow; a zero word keeps it high
                  state_next.pins.level[i] = (state_reg.cmp[i] == CCA_RST_CMP);
               end else if (match_ev[i]) begin
                  state_next.pins.level[i] = 1'b1;
               end
               flag_set[i] = state_reg.mode[i][CCA_B_MATCH] & match_ev[i];
            end
            CCA_IDLE: begin
               // a pulse mode with the comparator off sits low
               if (state_reg.mode[i][CCA_B_PULSE]) begin
                  state_next.pins.level[i] = 1'b0;
               end
            end
         endcase

         // Software writes follow hardware so the newest value sticks
         if (wr_mode[i]) begin
            state_next.mode[i] = avs_writedata[7:0];
         end
         if (wr_low[i]) begin
            state_next.cmp[i][7:0]           = avs_writedata[7:0];
            state_next.mode[i][CCA_B_CMP_EN] = 1'b0;
         end
         if (wr_high[i]) begin
            state_next.cmp[i][15:8]          = avs_writedata[7:0];
            state_next.mode[i][CCA_B_CMP_EN] = 1'b1;
         end
      end

      // only software clears; a set in the same edge wins
      state_next.flag = (state_reg.flag & ~flag_clr) | flag_set;

      // request while any enabled flag stands
      state_next.irq = 1'b0;
      for (int i = 0; i < CCA_MODULES; i++) begin
         if (state_reg.flag[i] & state_reg.mode[i][CCA_B_IRQ_EN]) begin
            state_next.irq = 1'b1;
         end
      end

      // Global registers
      if (wr_fire && hit(avs_address, CCA_OFF_CTRL) && avs_byteenable[0]) begin
         state_next.run = avs_writedata[0];
      end
      if (wr_fire && hit(avs_address, CCA_OFF_COUNT)) begin
         if (avs_byteenable[0]) begin
            state_next.count[7:0] = avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            state_next.count[15:8] = avs_writedata[15:8];
         end
      end

      // Read mux; unmapped addresses read zero
      if (hit(avs_address, CCA_OFF_CTRL)) begin
         rd[0] = state_reg.run;
      end else if (hit(avs_address, CCA_OFF_FLAGS)) begin
         rd[CCA_MODULES-1:0] = state_reg.flag;
      end else if (hit(avs_address, CCA_OFF_COUNT)) begin
         rd[15:0] = state_reg.count;
      end
      for (int i = 0; i < CCA_MODULES; i++) begin
         if (hit(avs_address, mod_base(i) + {4'h0, CCA_SUB_MODE})) begin
            rd[7:0] = state_reg.mode[i];
         end
         if (hit(avs_address, mod_base(i) + {4'h0, CCA_SUB_LOW})) begin
            rd[7:0] = state_reg.cmp[i][7:0];
         end
         if (hit(avs_address, mod_base(i) + {4'h0, CCA_SUB_HIGH})) begin
            rd[7:0] = state_reg.cmp[i][15:8];
         end
      end

      // Bus handshake: one wait cycle, then one ready cycle
      if (state_reg.wait_req) begin
         if (avs_read | avs_write) begin
            state_next.wait_req = 1'b0;
            state_next.rdata    = rd;
         end
      end else begin
         state_next.wait_req = 1'b1;
      end
   end

   // ==========================================================
   // State register; the clock enable freezes everything
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_reg            <= '0;
         state_reg.count      <= CCA_RST_COUNT;
         state_reg.mode       <= {CCA_MODULES{CCA_RST_MODE}};
         state_reg.cmp        <= {CCA_MODULES{CCA_RST_CMP}};
         state_reg.pins.oe_n  <= '1;
         state_reg.wait_req   <= 1'b1;
      end else if (ce_in) begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Checks, one set per module
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // Every module gets the same checks, since any module may run any mode
   for (gi = 0; gi < CCA_MODULES; gi++) begin : g_chk
      a_capture_loads_count: assert property (
         ce_in && cap_ev[gi] && !wr_low[gi] && !wr_high[gi]
         |=> state_reg.cmp[gi] == $past(state_reg.count))
         else $error("capture did not load the counter");

      a_capture_sets_flag: assert property (
         ce_in && cap_ev[gi] |=> state_reg.flag[gi])
         else $error("capture did not set the flag");

      a_flag_holds_set: assert property (
         ce_in && state_reg.flag[gi] && !flag_clr[gi] |=> state_reg.flag[gi])
         else $error("flag dropped without software clear");

      a_irq_follows_flag: assert property (
         ce_in && state_reg.flag[gi] && state_reg.mode[gi][CCA_B_IRQ_EN] |=> irq_out)
         else $error("interrupt not raised for enabled flag");

      a_low_write_disables: assert property (
         ce_in && wr_low[gi] |=> !state_reg.mode[gi][CCA_B_CMP_EN])
         else $error("low byte write left comparator on");

      a_high_write_enables: assert property (
         ce_in && wr_high[gi] |=> state_reg.mode[gi][CCA_B_CMP_EN])
         else $error("high byte write left comparator off");

      a_timer_match_flag: assert property (
         ce_in && md[gi] == CCA_TIMER && match_ev[gi] |=> state_reg.flag[gi])
         else $error("timer match did not set the flag");

      a_hso_toggles: assert property (
         ce_in && md[gi] == CCA_HSO && match_ev[gi]
         |=> state_reg.pins.level[gi] != $past(state_reg.pins.level[gi]))
         else $error("high-speed output did not toggle");

      a_freq_step_add: assert property (
         ce_in && md[gi] == CCA_FREQ && match_ev[gi] && !wr_low[gi] && !wr_mode[gi]
         |=> state_reg.cmp[gi][7:0] == 8'($past(state_reg.cmp[gi][7:0])
                                          + $past(state_reg.cmp[gi][15:8])))
         else $error("frequency step not added");

      a_pwm8_reload: assert property (
         ce_in && md[gi] == CCA_PWM8 && ovf8 && !wr_low[gi]
         |=> state_reg.cmp[gi][7:0] == $past(state_reg.cmp[gi][15:8]))
         else $error("pwm8 low byte not reloaded");

      a_pwm16_overflow_low: assert property (
         ce_in && md[gi] == CCA_PWM16 && ovf16 && state_reg.cmp[gi] != CCA_RST_CMP
         |=> !state_reg.pins.level[gi])
         else $error("pwm16 line not low after overflow");

      a_sync_latency: assert property (
         ce_in [*3] ##0 (md[gi] == CCA_CAPTURE) && state_reg.mode[gi][CCA_B_CAP_R]
         && $rose(state_reg.sync2[gi]) |-> cap_ev[gi] || !ce_in)
         else $error("synchronised rise not captured");
   end

endmodule

// file: include/cca_pkg.sv
// Package for the counter-array capture/compare block.
// It holds the register map, the field positions, the reset values and the state types.
// It assumes one system clock and a 32-bit Avalon-MM register bus.
package cca_pkg;

   // ==========================================================
   // Sizes
   localparam int CCA_MODULES = 5;            // Number of capture/compare modules
   localparam int CCA_CNT_W   = 16;           // Counter and compare word width
   localparam int CCA_ADDR_W  = 8;            // Byte address width of the bus

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] CCA_OFF_CTRL   = 8'h00;  // Bit 0: counter run
   localparam logic [7:0] CCA_OFF_FLAGS  = 8'h04;  // Match flags, write one to clear
   localparam logic [7:0] CCA_OFF_COUNT  = 8'h08;  // 16-bit counter, read/write
   localparam logic [7:0] CCA_OFF_MOD0   = 8'h40;  // First module window
   localparam logic [7:0] CCA_MOD_STRIDE = 8'h10;  // Bytes per module window
   localparam logic [3:0] CCA_SUB_MODE   = 4'h0;   // module_mode_reg
   localparam logic [3:0] CCA_SUB_LOW    = 4'h4;   // compare_low_byte
   localparam logic [3:0] CCA_SUB_HIGH   = 4'h8;   // compare_high_byte

   // ==========================================================
   // module_mode_reg field positions
   localparam int CCA_B_IRQ_EN  = 0;   // module_irq_enable
   localparam int CCA_B_PULSE   = 1;   // pulse_mode_enable
   localparam int CCA_B_TOGGLE  = 2;   // toggle_enable
   localparam int CCA_B_MATCH   = 3;   // match_flag_enable
   localparam int CCA_B_CAP_F   = 4;   // falling_capture_enable
   localparam int CCA_B_CAP_R   = 5;   // rising_capture_enable
   localparam int CCA_B_CMP_EN  = 6;   // comparator_enable
   localparam int CCA_B_WIDE    = 7;   // wide_pulse_select

   // ==========================================================
   // Reset values
   localparam logic [7:0]  CCA_RST_MODE  = 8'h00;
   localparam logic [15:0] CCA_RST_CMP   = 16'h0000;
   localparam logic [15:0] CCA_RST_COUNT = 16'h0000;
   localparam logic [7:0]  CCA_LOW_WRAP  = 8'h00;   // Low byte value right after overflow

   // ==========================================================
   // Operating modes of one module
   typedef enum logic [2:0] {
      CCA_IDLE,
      CCA_CAPTURE,
      CCA_TIMER,
      CCA_HSO,
      CCA_FREQ,
      CCA_PWM8,
      CCA_PWM16
   } cca_mode_type;

   // Pins of the module_io_line group
   typedef struct packed {
      logic [CCA_MODULES-1:0] level;    // Drive level
      logic [CCA_MODULES-1:0] oe_n;     // Low while the module drives the line
   } cca_pins_type;

   // Whole state of the block
   typedef struct packed {
      logic [CCA_CNT_W-1:0]                   count;     // Shared timebase counter
      logic                                   run;       // Counter run enable
      logic [CCA_MODULES-1:0]                 flag;      // module_match_flag bits
      logic [CCA_MODULES-1:0][7:0]            mode;      // module_mode_reg copies
      logic [CCA_MODULES-1:0][CCA_CNT_W-1:0]  cmp;       // compare_word per module
      cca_pins_type                           pins;      // Line drive state
      logic [CCA_MODULES-1:0]                 sync1;     // First synchroniser stage
      logic [CCA_MODULES-1:0]                 sync2;     // Second synchroniser stage
      logic [CCA_MODULES-1:0]                 prev;      // Last synchronised level
      logic                                   wait_req;  // Avalon waitrequest
      logic [31:0]                            rdata;     // Avalon readdata
      logic                                   irq;       // Combined request
   } cca_state_type;

endpackage

// file: dv/cca_pin_model.sv
// Pin-side model: drives the five module lines toward the levels the bench asks for.
// Assumes the bench clock; never changes a line sooner than two clocks after its last change.
`timescale 1ns/1ps
module cca_pin_model (
   input  wire logic       clk_in,    // System clock
   input  wire logic       rst_n_in,  // Synchronous reset, low
   input  wire logic [4:0] want_in,   // Levels asked by the bench
   output logic [4:0]      line_out   // Levels on the pins
);
   logic [1:0] held_reg;  // Clocks the present levels have stood
   // ==========================================
   // Line driver
   // two clock hold
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         line_out <= 5'h00;
         held_reg <= 2'h0;
      end else if (want_in != line_out && held_reg >= 2'h2) begin
         line_out <= want_in;
         held_reg <= 2'h1;
      end else if (held_reg != 2'h3) begin
         held_reg <= held_reg + 2'h1;
      end
   end
endmodule

// file: dv/test_counter_array_capture_compare_modules.sv
// Self-checking bench: capture, timer, toggle, PWM8 and frequency modes over Avalon-MM.
// Assumes one 100 MHz clock and a timebase tick on every clock except the 20 clocks where t_freeze holds tick low.
`timescale 1ns/1ps
module test_counter_array_capture_compare_modules;
   import cca_pkg::*;
   logic         clk_in, rst_n_in, avs_read, avs_write, avs_waitrequest, irq_out;
   logic [7:0]   avs_address;             // Bus address
   logic [31:0]  avs_writedata, avs_readdata, rd;
   logic [4:0]   want, line;              // Pin requests and pin levels
   logic         ce, tick;                // Clock enable and timebase tick
   cca_pins_type pins;                    // Line drive from the block
   int           miscompares, total_checks;
   cca_pin_model u_pins (.clk_in(clk_in), .rst_n_in(rst_n_in), .want_in(want), .line_out(line));
   cca_core u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .tick_in(tick),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .io_line_in(line), .io_line_out(pins),
      .irq_out(irq_out));
   // ==========================================
   // Shared tasks
   task automatic end_sim();
      $display("Checks %0d, miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One bus cycle; request held until waitrequest is seen low
   task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
      int n;
      @(posedge clk_in);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin @(posedge clk_in); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin miscompares++; end_sim(); end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   function automatic logic [7:0] ma(int i, logic [3:0] sub);
      return 8'(CCA_OFF_MOD0 + CCA_MOD_STRIDE * i + sub);
   endfunction
   // Waits for a level, then counts the clocks it stands
   task automatic hold(int i, logic v, int exp);
      int n;
      n = 0;
      while (pins.level[i] !== v && n < 1000) begin @(posedge clk_in); n++; end
      if (pins.level[i] !== v) begin miscompares++; end_sim(); end
      n = 0;
      while (pins.level[i] === v && n < 1000) begin @(posedge clk_in); n++; end
      check("level time", n[15:0], exp[15:0]);
      if (pins.level[i] === v) begin end_sim(); end
   endtask
   // ==========================================
   // Scenarios
   task automatic t_capture();
      bus(1, CCA_OFF_COUNT, 32'h1234);
      // module enable set; array and global gating sit outside
      bus(1, ma(0, CCA_SUB_MODE), 32'h21);
      want <= 5'h01;
      repeat (12) @(posedge clk_in);
      check("irq", irq_out, 1'b1);
      bus(0, ma(0, CCA_SUB_LOW), 0);
      check("cap low", rd[7:0], 8'h34);
      bus(0, ma(0, CCA_SUB_HIGH), 0);
      check("cap high", rd[7:0], 8'h12);
      bus(0, CCA_OFF_FLAGS, 0);
      check("flag held", rd[4:0], 5'h01);
      bus(1, CCA_OFF_FLAGS, 32'h1f);
      bus(1, ma(0, CCA_SUB_MODE), 32'h11);
      bus(1, CCA_OFF_COUNT, 32'h0abc);
      want <= 5'h00;
      repeat (12) @(posedge clk_in);
      bus(0, ma(0, CCA_SUB_HIGH), 0);
      check("fall cap", rd[7:0], 8'h0a);
      bus(1, CCA_OFF_FLAGS, 32'h1f);
      bus(0, CCA_OFF_FLAGS, 0);
      check("flag clear", rd[4:0], 5'h00);
   endtask
   task automatic t_compare();
      bus(1, ma(1, CCA_SUB_MODE), 32'h48);
      bus(1, ma(2, CCA_SUB_MODE), 32'h4c);
      for (int i = 1; i < 3; i++) begin
         bus(1, ma(i, CCA_SUB_LOW), 32'h40);
         bus(0, ma(i, CCA_SUB_MODE), 0);
         check("cmp off", rd[CCA_B_CMP_EN], 1'b0);
         bus(1, ma(i, CCA_SUB_HIGH), 32'h00);
         bus(0, ma(i, CCA_SUB_MODE), 0);
         check("cmp on", rd[CCA_B_CMP_EN], 1'b1);
      end
      bus(1, CCA_OFF_COUNT, 32'h0000);
      bus(1, CCA_OFF_CTRL, 32'h1);
      // Run lands one edge before the first increment: 64 ticks plus one
      hold(2, 1'b0, 16'h41);
      bus(0, CCA_OFF_FLAGS, 0);
      check("timer flags", rd[2:1], 2'h3);
   endtask
   task automatic t_pwm_freq();
      bus(1, ma(3, CCA_SUB_MODE), 32'h42);
      // low first; first period uses it, later ones the reload
      bus(1, ma(3, CCA_SUB_LOW), 32'h80);
      bus(1, ma(3, CCA_SUB_HIGH), 32'hc0);
      hold(3, 1'b1, 128);
      hold(3, 1'b1, 64);
      bus(0, ma(3, CCA_SUB_LOW), 0);
      check("reload", rd[7:0], 8'hc0);
      bus(1, ma(4, CCA_SUB_MODE), 32'h46);
      bus(1, ma(4, CCA_SUB_LOW), 32'h00);
      bus(1, ma(4, CCA_SUB_HIGH), 32'h04);
      hold(4, 1'b1, 4);
      check("oe", pins.oe_n, 5'h03);
   endtask
   // Counter steps between two reads must not grow while ce or tick is low
   task automatic t_freeze();
      logic [15:0] c0, d0, d1, d2;
      bus(0, CCA_OFF_COUNT, 0);
      c0 = rd[15:0];
      bus(0, CCA_OFF_COUNT, 0);
      d0 = rd[15:0] - c0;
      c0 = rd[15:0];
      ce <= 1'b0;
      repeat (20) @(posedge clk_in);
      ce <= 1'b1;
      bus(0, CCA_OFF_COUNT, 0);
      d1 = rd[15:0] - c0;
      c0 = rd[15:0];
      tick <= 1'b0;
      repeat (20) @(posedge clk_in);
      tick <= 1'b1;
      bus(0, CCA_OFF_COUNT, 0);
      d2 = rd[15:0] - c0;
      check("ce freeze", d1, d0);
      check("tick hold", d2, d0);
   endtask
   task automatic t_pwm16();
      bus(1, CCA_OFF_COUNT, 32'hfe00);
      // match flag and interrupt on to pace updates
      bus(1, ma(0, CCA_SUB_MODE), 32'hcb);
      bus(1, ma(0, CCA_SUB_LOW), 32'h00);
      bus(1, ma(0, CCA_SUB_HIGH), 32'hff);
      hold(0, 1'b1, 256);
      check("pwm16 irq", irq_out, 1'b1);
   endtask
   // ==========================================
   // Clock, reset and run
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      {rst_n_in, avs_read, avs_write, avs_address, avs_writedata, want} = '0;
      ce = 1'b1;
      tick = 1'b1;
      miscompares = 0;
      total_checks = 0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      bus(0, ma(0, CCA_SUB_MODE), 0);
      check("mode reset", rd[7:0], CCA_RST_MODE);
      check("oe reset", pins.oe_n, 5'h1f);
      t_capture();
      t_compare();
      t_pwm_freq();
      t_freeze();
      t_pwm16();
      end_sim();
   end
endmodule
